// [bit_timer_pkg.sv]
// Package with register map, field positions, reset values and types of the bit timer.
package bit_timer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int COUNT_W = 10;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h00c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_CNT_HI_MSB = 7;
  localparam int CTL_CNT_HI_LSB = 6;
  localparam int CTL_MODE_MSB = 5;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_IE_BIT = 3;
  localparam int CTL_DONE_BIT = 2;
  localparam int CTL_DATA_BIT = 1;
  localparam int CTL_BUF_BIT = 0;

  // Interrupt status and mask layout.
  localparam int IRQ_BUF_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // Reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_LOW_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [7:0] VECTOR_BUF = 8'h04;
  localparam logic [7:0] VECTOR_DONE = 8'h02;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_GENERIC = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_TX = 2'h3;

  typedef enum logic [0:0] {TX_IDLE, TX_RUN} tx_state_type;

endpackage

// [interval_if.sv]
// Interface between the bit timer control logic and its interval counter.
`timescale 1ns/1ps
interface interval_if;
  import bit_timer_pkg::*;
  logic clear;
  logic load;
  logic run;
  logic down;
  logic [COUNT_W-1:0] load_value;
  logic [COUNT_W-1:0] value;
  logic expired;
  logic overflow;
  modport ctrl (output clear, load, run, down, load_value, input value, expired, overflow);
  modport counter (input clear, load, run, down, load_value, output value, expired, overflow);
endinterface

// [interval_counter.sv]
// Ten-bit interval counter that counts down for transmit and up for receive.
`timescale 1ns/1ps
module interval_counter
  import bit_timer_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control side
  interval_if.counter iv
);

  logic [COUNT_W-1:0] value_reg;
  logic [COUNT_W-1:0] value_next;

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  wire at_zero = (value_reg == '0);
  wire at_top = (value_reg == {COUNT_W{1'b1}});

  // Down counting stops at zero; up counting wraps and flags it.
  assign value_next = iv.clear ? '0 :
                      iv.load ? iv.load_value :
                      !iv.run ? value_reg :
                      iv.down ? (at_zero ? value_reg : value_reg - 1'b1) :
                      value_reg + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= '0;
    end else if (clk_en) begin
      value_reg <= value_next;
    end
  end

  assign iv.value = value_reg;
  assign iv.expired = iv.run && iv.down && at_zero;
  // An edge that meets the top value still reports the wrap, since the latched count is lost.
  assign iv.overflow = iv.run && !iv.down && at_top;

endmodule

// [bit_timer.sv]
// Bit timer with one-bit transmit buffer, edge interval capture and APB registers.
`timescale 1ns/1ps
// Notes on behaviour
// R01: With interrupt enable set, each flag raises its interrupt; vectors 0x04 and 0x02.
// R02: Transmit: done flag sets when buffer is empty and counter reached zero.
// R03: Receive mode sets the done flag on every capture pin edge.
// R04: Done flag idle in mode 00; modes 01 and 11 report transmit done.
// R05: Reading the control register clears both flags.
// R06: Transmit: the data bit is a one-bit buffer feeding the next sent bit.
// R07: Taking the buffered bit sets the buffer flag and its interrupt when enabled.
// R08: Software refills the buffer in its handler or polls the buffer flag.
// R09: Receive: the data bit shows edge polarity, one rising, zero falling.
// R10: Receive: the count holds clock cycles since the previous edge.
// R11: Receive: counter overflow before the next edge sets the overflow flag.
// R12: Software extends long intervals by counting overflow flags.
// R13: Mode 00 off, 01 generic, 10 receive, 11 transmit.
// R14: The count is the low count register plus control bits 7:6.
// R15: Each mark or space lasts count plus one clock periods.
// R16: Receive: counter restarts from zero at each edge after latching.
// R17: Keying holds the buffered bit for the full interval before the next fetch.
module bit_timer
  import bit_timer_pkg::*;
#(
  parameter int CNT_WIDTH = COUNT_W
)
(
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side
  input wire logic capture_pin,
  output logic tx_key,
  // Interrupts
  output logic bit_buffer_interrupt,
  output logic done_interrupt,
  output logic [7:0] irq_vector,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The register layout fixes the count at ten bits.
  if (CNT_WIDTH != COUNT_W) begin : g_bad_width
    $error("bit_timer: CNT_WIDTH must be 10");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  interval_if iv ();
  tx_state_type state_reg, state_next;
  logic [7:0] count_low_reg;
  logic [1:0] count_hi_reg;
  logic [1:0] mode_reg;
  logic ie_reg, data_reg, buf_full_reg, buffer_or_overflow_flag_reg, done_or_edge_flag_reg, key_reg;
  logic [COUNT_W-1:0] cap_count_reg;
  logic cap_pol_reg;
  logic sync1_reg, sync2_reg, prev_reg;
  logic [IRQ_W-1:0] status_reg, mask_reg;
  logic [31:0] rdata_reg;
  logic [7:0] vector_reg;

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable && clk_en;
  wire hit_count = (paddr == OFF_COUNT_LOW);
  wire hit_ctrl = (paddr == OFF_CONTROL);
  wire hit_stat = (paddr == OFF_IRQ_STATUS);
  wire hit_mask = (paddr == OFF_IRQ_MASK);
  wire mapped = hit_count || hit_ctrl || hit_stat || hit_mask;
  wire wr_ok = access && pwrite && pstrb[0] && mapped;
  wire wr_count = wr_ok && hit_count;
  wire wr_ctrl = wr_ok && hit_ctrl;
  wire wr_stat = wr_ok && hit_stat;
  wire wr_mask = wr_ok && hit_mask;
  wire ctrl_read = access && !pwrite && hit_ctrl;
  wire [1:0] wr_mode = pwdata[CTL_MODE_MSB:CTL_MODE_LSB];
  wire wr_fill = wr_ctrl && (wr_mode != MODE_RX) && (wr_mode != MODE_OFF); // R06

  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_reg;

  // ----------------------------------------------------------------
  // Mode decode and pin sampling
  // ----------------------------------------------------------------
  wire mode_tx = (mode_reg == MODE_TX); // R13
  wire mode_rx = (mode_reg == MODE_RX); // R13
  wire mode_off = (mode_reg == MODE_OFF); // R13
  wire tx_active = mode_tx || (mode_reg == MODE_GENERIC); // R04
  wire [COUNT_W-1:0] count_val = {count_hi_reg, count_low_reg}; // R14
  wire rx_edge = mode_rx && (sync2_reg != prev_reg); // R03

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  wire in_run = (state_reg == TX_RUN);
  wire bit_end = in_run && iv.expired;
  wire fetch = tx_active && buf_full_reg && (!in_run || bit_end); // R06 R17
  wire tx_done = tx_active && bit_end && !buf_full_reg; // R02

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TX_IDLE: begin
        if (fetch) begin
          state_next = TX_RUN;
        end
      end
      TX_RUN: begin
        if (!tx_active || tx_done) begin
          state_next = TX_IDLE;
        end
      end
      default: begin
        state_next = TX_IDLE;
      end
    endcase
  end

  // Counter steering: load the interval on a fetch, count up between edges.
  assign iv.clear = !mode_rx && !tx_active || rx_edge; // R16
  assign iv.load = fetch; // R15
  assign iv.load_value = count_val; // R15
  assign iv.run = (tx_active && in_run) || mode_rx;
  assign iv.down = tx_active;

  interval_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .iv(iv.counter)
  );

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire set0 = fetch || (mode_rx && iv.overflow); // R07 R11
  wire set2 = tx_done || rx_edge; // R02 R03
  // Only bits that the read returned are cleared, so a later set is not lost.
  wire clr0 = ctrl_read && rdata_reg[CTL_BUF_BIT]; // R05
  wire clr2 = ctrl_read && rdata_reg[CTL_DONE_BIT]; // R05
  wire [IRQ_W-1:0] events = {set2, set0};
  wire [IRQ_W-1:0] stat_clr = wr_stat ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_or_overflow_flag_reg <= 1'b0;
      done_or_edge_flag_reg <= 1'b0;
      status_reg <= '0;
    end else if (clk_en) begin
      buffer_or_overflow_flag_reg <= set0 || (buffer_or_overflow_flag_reg && !clr0); // R05 R07 R11
      done_or_edge_flag_reg <= !mode_off && (set2 || (done_or_edge_flag_reg && !clr2)); // R04 R05
      status_reg <= events | (status_reg & ~stat_clr);
    end
  end

  // ----------------------------------------------------------------
  // Control registers and buffer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_reg <= COUNT_LOW_RESET;
      {count_hi_reg, mode_reg, ie_reg} <= CONTROL_RESET[7:3];
      data_reg <= CONTROL_RESET[CTL_DATA_BIT];
      mask_reg <= IRQ_MASK_RESET;
    end else if (clk_en) begin
      if (wr_count) begin
        count_low_reg <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        count_hi_reg <= pwdata[CTL_CNT_HI_MSB:CTL_CNT_HI_LSB];
        mode_reg <= pwdata[CTL_MODE_MSB:CTL_MODE_LSB];
        ie_reg <= pwdata[CTL_IE_BIT];
        data_reg <= pwdata[CTL_DATA_BIT]; // R06
      end
      if (wr_mask) begin
        mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // A write in the fetch cycle refills the buffer after the old bit is taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_full_reg <= 1'b0;
      state_reg <= TX_IDLE;
      key_reg <= 1'b0;
    end else if (clk_en) begin
      buf_full_reg <= wr_fill || (buf_full_reg && !fetch && tx_active); // R06
      state_reg <= state_next;
      if (fetch) begin
        key_reg <= data_reg; // R17
      end else if (tx_done || !tx_active) begin
        key_reg <= 1'b0;
      end
    end
  end

  assign tx_key = key_reg && mode_tx;

  // ----------------------------------------------------------------
  // Receive capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      cap_count_reg <= '0;
      cap_pol_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= capture_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      // The edge cycle itself belongs to the interval, hence the plus one.
      if (rx_edge) begin
        cap_count_reg <= COUNT_W'(iv.value + 1'b1); // R10
        cap_pol_reg <= sync2_reg; // R09
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, sampled in the setup phase
  // ----------------------------------------------------------------
  wire [COUNT_W-1:0] shown_count = mode_rx ? cap_count_reg : count_val; // R10
  wire shown_data = mode_rx ? cap_pol_reg : data_reg; // R09
  wire [7:0] ctrl_view = {shown_count[9:8], mode_reg, ie_reg, done_or_edge_flag_reg, shown_data,
                          buffer_or_overflow_flag_reg};
  wire [31:0] rd_mux = hit_count ? byte_word(shown_count[7:0]) :
                       hit_ctrl ? byte_word(ctrl_view) :
                       hit_stat ? {30'h00000000, status_reg} :
                       hit_mask ? {30'h00000000, mask_reg} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
      vector_reg <= 8'h00;
    end else if (clk_en) begin
      if (setup) begin
        rdata_reg <= rd_mux;
      end
      // The done vector is served first when both flags stand.
      vector_reg <= (ie_reg && done_or_edge_flag_reg) ? VECTOR_DONE :
                    (ie_reg && buffer_or_overflow_flag_reg) ? VECTOR_BUF : 8'h00; // R01
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  assign bit_buffer_interrupt = ie_reg && buffer_or_overflow_flag_reg; // R01 R07
  assign done_interrupt = ie_reg && done_or_edge_flag_reg; // R01
  assign irq_vector = vector_reg;
  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [COUNT_W:0] bit_cycles_reg, bit_len_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cycles_reg <= '0;
      bit_len_reg <= '0;
    end else if (clk_en) begin
      if (fetch) begin
        bit_cycles_reg <= (COUNT_W+1)'(1);
        bit_len_reg <= {1'b0, count_val} + 1'b1;
      end else if (in_run) begin
        bit_cycles_reg <= bit_cycles_reg + 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_clears: assert property (clr0 && !set0 |=> !buffer_or_overflow_flag_reg) // R05
    else $error("buffer flag survived control read");
  a_fetch_flag: assert property (fetch && clk_en // R07
    |=> buffer_or_overflow_flag_reg && buf_full_reg == $past(wr_fill))
    else $error("fetch did not set buffer flag");
  a_done_flag: assert property (tx_done && clk_en |=> done_or_edge_flag_reg && state_reg == TX_IDLE) // R02
    else $error("transmit done not flagged");
  a_off_quiet: assert property (mode_off && clk_en |=> !done_or_edge_flag_reg) // R04
    else $error("done flag set while disabled");
  a_edge_capture: assert property (rx_edge && clk_en // R03
    |=> done_or_edge_flag_reg && cap_pol_reg == $past(sync2_reg))
    else $error("edge not captured");
  a_rx_restart: assert property (rx_edge && clk_en |=> iv.value == '0) // R16
    else $error("counter not restarted at edge");
  a_overflow_flag: assert property (mode_rx && iv.overflow && clk_en |=> buffer_or_overflow_flag_reg) // R11
    else $error("overflow not flagged");
  a_bit_length: assert property (bit_end && clk_en |-> bit_cycles_reg == bit_len_reg) // R15
    else $error("bit interval length wrong");
  a_key_stable: assert property ($past(in_run && !bit_end) && $past(mode_tx) && mode_tx // R17
    |-> $stable(tx_key))
    else $error("key changed inside interval");
  a_irq_vector: assert property (ie_reg && buffer_or_overflow_flag_reg && !done_or_edge_flag_reg && clk_en // R01
    |=> irq_vector == VECTOR_BUF)
    else $error("buffer vector wrong");

  c_fetch: cover property (fetch ##[1:40] fetch);
  c_done: cover property (tx_done);
  c_rx_edge: cover property (rx_edge ##[1:100] rx_edge);
  c_overflow: cover property (mode_rx && iv.overflow);

endmodule

// [link_partner.sv]
// Far-side model of the bit timer: drives the capture pin and measures keying pulses.
`timescale 1ns/1ps
module link_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic tx_key,
  output logic capture_pin
);
  // ----------------------------------------------------------------
  // Keying measurement
  // ----------------------------------------------------------------
  int run_len = 0;
  int high_len = 0;
  int ones = 0;

  initial capture_pin = 1'b0;

  // Whole cycles are counted at the rising edge, so a mark of count plus one
  // cycles shows up here as exactly that number.
  always @(posedge pclk) begin
    if (presetn === 1'b1 && tx_key === 1'b1) begin
      run_len <= run_len + 1;
      ones <= ones + 1;
    end else begin
      if (run_len != 0) high_len <= run_len;
      run_len <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Capture pin stimulus
  // ----------------------------------------------------------------
  // Two edges, the second one gap cycles after the first.
  task automatic edge_pair(input int gap);
    @(posedge pclk);
    capture_pin <= ~capture_pin;
    repeat (gap) @(posedge pclk);
    capture_pin <= ~capture_pin;
  endtask
endmodule

// [bit_timer_tb.sv]
// Self-checking testbench of the bit timer over APB with a far-side link model.
`timescale 1ns/1ps
module bit_timer_tb;
  import bit_timer_pkg::*;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic pclk, presetn, clk_en, psel, penable, pwrite, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, capture_pin, tx_key, bit_buffer_interrupt, done_interrupt, irq;
  logic [7:0] irq_vector;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ones0;
  int overflows = 0;

`define CHECK(name, exp, act) begin \
  cmp_count++; \
  if ((act) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, act); \
  end \
end

  bit_timer u_bit_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .tx_key(tx_key), .bit_buffer_interrupt(bit_buffer_interrupt),
    .done_interrupt(done_interrupt), .irq_vector(irq_vector), .irq(irq));

  link_partner u_link_partner (.pclk(pclk), .presetn(presetn), .tx_key(tx_key),
    .capture_pin(capture_pin));

  // ----------------------------------------------------------------
  // Bus and wait tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string n);
    apb(1'b0, a, 32'h0);
    `CHECK(n, e, rd & m)
  endtask

  // Waits a bounded number of cycles for one of the interrupt lines.
  task automatic wait_irq(input bit sel_done, input int lim);
    int i;
    i = 0;
    // Let the edge that ended the last call settle, so a flag it clears is not seen.
    #1;
    while ((sel_done ? done_interrupt : bit_buffer_interrupt) !== 1'b1 && i < lim) begin
      @(posedge pclk);
      #1;
      i++;
    end
    `CHECK("interrupt", 1'b1, sel_done ? done_interrupt : bit_buffer_interrupt)
  endtask

  task automatic step;
    @(posedge pclk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The whole run needs about 2000 cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdx(OFF_COUNT_LOW, 32'h0, '1, "count_low");
    rdx(OFF_CONTROL, 32'h0, '1, "control");
    rdx(OFF_IRQ_MASK, 32'h0, '1, "irq_mask");
    rdx(12'h010, 32'h0, '1, "unmapped");
    `CHECK("pslverr", 1'b1, err)
    pstrb <= 4'h0;
    wr(OFF_COUNT_LOW, 32'h55);
    pstrb <= 4'hf;
    rdx(OFF_COUNT_LOW, 32'h0, '1, "strobe");
    $display("test reset_and_map done");
    // Transmit: count 0x102 gives marks of 259 cycles.
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_COUNT_LOW, 32'h02);
    wr(OFF_CONTROL, 32'h7a);
    wait_irq(1'b0, 20);
    `CHECK("tx_key", 1'b1, tx_key)
    step();
    `CHECK("vector", VECTOR_BUF, irq_vector)
    `CHECK("irq", 1'b1, irq)
    rdx(OFF_IRQ_STATUS, 32'h1, 32'h3, "irq_status");
    wr(OFF_IRQ_STATUS, 32'h1);
    rdx(OFF_IRQ_STATUS, 32'h0, 32'h1, "w1c");
    wr(OFF_CONTROL, 32'h78);
    wait_irq(1'b1, 700);
    `CHECK("mark", 259, u_link_partner.high_len)
    `CHECK("idle key", 1'b0, tx_key)
    step();
    `CHECK("vector", VECTOR_DONE, irq_vector)
    rdx(OFF_CONTROL, 32'h7d, 32'hfd, "done");
    rdx(OFF_CONTROL, 32'h0, 32'h05, "read clear");
    step();
    `CHECK("done irq", 1'b0, done_interrupt)
    wr(OFF_IRQ_MASK, 32'h0);
    step();
    `CHECK("masked", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h3);
    step();
    `CHECK("unmasked", 1'b1, irq)
    wr(OFF_IRQ_STATUS, 32'h3);
    step();
    `CHECK("cleared", 1'b0, irq)
    $display("test transmit done");
    // Generic mode times like transmit but never keys.
    ones0 = u_link_partner.ones;
    wr(OFF_COUNT_LOW, 32'h03);
    wr(OFF_CONTROL, 32'h1a);
    wait_irq(1'b1, 40);
    `CHECK("no keying", ones0, u_link_partner.ones)
    rdx(OFF_CONTROL, 32'h1d, 32'hfd, "generic");
    wr(OFF_CONTROL, 32'h08);
    repeat (20) step();
    rdx(OFF_CONTROL, 32'h08, 32'hfd, "off");
    $display("test modes done");
    // Receive: rising edge, then a falling edge 300 cycles later.
    wr(OFF_CONTROL, 32'h28);
    apb(1'b0, OFF_CONTROL, 32'h0);
    wr(OFF_IRQ_STATUS, 32'h3);
    fork
      u_link_partner.edge_pair(300);
    join_none
    wait_irq(1'b1, 20);
    rdx(OFF_CONTROL, 32'h2e, 32'h3e, "rise");
    wait_irq(1'b1, 320);
    rdx(OFF_COUNT_LOW, 32'h2c, '1, "interval");
    rdx(OFF_CONTROL, 32'h6c, '1, "fall");
    clk_en <= 1'b0;
    repeat (20) step();
    `CHECK("frozen ready", 1'b0, pready)
    `CHECK("frozen flag", 1'b0, bit_buffer_interrupt)
    @(posedge pclk);
    clk_en <= 1'b1;
    wait_irq(1'b0, 1100);
    overflows++;
    rdx(OFF_IRQ_STATUS, 32'h1, 32'h1, "overflow");
    $display("test receive done, overflows %0d", overflows);
    tally_and_finish();
  end
endmodule
